/* hw/README_unused.v */
`default_nettype none
`default_nettype wire

/* hw/tbd_tx_cmd_decoder.v */
// Transmit buffer command decoder with register port and interrupt.
//
// Summary of operation
// (RULE1) Every buffer opens with two 32-bit command words, A then B.
// (RULE2) The host repeats both words before each buffer of a packet.
// (RULE3) Word B must match across a packet, else the error flag rises.
// (RULE4) The 16-bit tag of word B is returned with the packet status.
// (RULE5) Bit 31 of A raises the done flag once the buffer is loaded.
// (RULE6) The done flag reaches the interrupt output under a mask bit.
// (RULE7) The host writes zeros into bits 30 to 26 of word A.
// (RULE8) Bits 25:24 of A pick 4, 16 or 32 byte end alignment.
// (RULE9) The host appends filler words up to the chosen alignment.
// (RULE10) Filler words are swallowed and never sent on.
// (RULE11) Bits 20:16 of A give a 0 to 31 byte start offset to skip.
// (RULE12) Bits 13 and 12 of A mark first and last segment of a packet.
// (RULE13) Buffer sizes are summed and checked against the B length.
// (RULE14) Bits 10:0 of B give packet length; a mismatch is an error.
// (RULE15) Bit 13 of B drops the CRC, bit 12 drops padding but keeps CRC.
// (RULE16) Bits 23 to 21 of A are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "tbd_tx_cmd_defs.vh"

module tbd_tx_cmd_decoder (
    input  wire        core_clk_in,
    input  wire        resetn_in,
    input  wire [31:0] fifo_word_in,
    input  wire        fifo_valid_in,
    output wire        fifo_ready_out,

    output reg  [7:0]  tx_byte_out,
    output reg         tx_byte_valid_out,
    output reg         tx_byte_last_out,
    output reg         tx_crc_add_out,
    output reg         tx_pad_en_out,

    output reg         status_valid_out,
    output reg  [15:0] status_tag_out,
    output reg         status_error_out,

    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_write_in,
    input  wire        reg_read_in,
    output reg  [31:0] reg_rdata_out,

    output wire        irq_out
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_CMD_A = 2'd0;
    localparam [1:0] ST_CMD_B = 2'd1;
    localparam [1:0] ST_DATA  = 2'd2;

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg [1:0]  state_reg;
    reg        a_irq_reg;
    reg        a_first_reg;
    reg        a_last_reg;
    reg        a_align_err_reg;
    reg [4:0]  a_off_reg;
    reg [10:0] a_size_reg;
    reg [11:0] a_end_reg;
    reg [11:0] words_total_reg;
    reg [11:0] word_idx_reg;
    reg        hold_reg;
    reg [1:0]  lane_reg;
    reg [31:0] data_reg;

    reg [31:0] pkt_b_reg;
    reg        pkt_open_reg;
    reg [11:0] pkt_sum_reg;
    reg        pkt_err_reg;

    reg [`TBD_STS_W-1:0] sts_reg;
    reg [`TBD_STS_W-1:0] mask_reg;

    // ****************************************************************
    // Word handshake
    // ****************************************************************
    // Data words wait while the held word is spread into bytes
    assign fifo_ready_out = (state_reg != ST_DATA) || !hold_reg;

    wire take_a    = fifo_valid_in && fifo_ready_out
                     && (state_reg == ST_CMD_A);
    wire take_b    = fifo_valid_in && fifo_ready_out
                     && (state_reg == ST_CMD_B);
    wire take_data = fifo_valid_in && fifo_ready_out
                     && (state_reg == ST_DATA);

    // ****************************************************************
    // Buffer geometry from word A
    // ****************************************************************
    // Bits 30:26 and 23:21 never enter any term below [RULE7] [RULE16]
    wire [4:0]  in_off   = fifo_word_in[`TBD_A_OFF_HI:`TBD_A_OFF_LO];
    wire [10:0] in_size  = fifo_word_in[`TBD_A_SIZE_HI:`TBD_A_SIZE_LO];
    wire [1:0]  in_align = fifo_word_in[`TBD_A_ALIGN_HI:`TBD_A_ALIGN_LO];
    wire [11:0] in_end   = {7'b000_0000, in_off} + {1'b0, in_size};
    wire [12:0] in_end3  = {1'b0, in_end} + 13'h0003;
    wire [11:0] in_words = {1'b0, in_end3[12:2]};
    reg  [11:0] in_amask;

    // Rounding mask per end alignment; reserved code falls back [RULE8]
    always @* begin
        case (in_align)
            `TBD_ALIGN_16: in_amask = `TBD_AMASK_16;
            `TBD_ALIGN_32: in_amask = `TBD_AMASK_32;
            default:       in_amask = `TBD_AMASK_4;
        endcase
    end

    // Words the host sends, filler included [RULE9]
    wire [11:0] in_total = (in_words + in_amask) & ~in_amask;

    // ****************************************************************
    // Packet checks on word B
    // ****************************************************************
    wire        b_mismatch = pkt_open_reg && !a_first_reg
                             && (fifo_word_in != pkt_b_reg); // [RULE3]
    // Segment marks out of order break packet delimiting [RULE12]
    wire        b_delim    = (a_first_reg && pkt_open_reg)
                             || (!a_first_reg && !pkt_open_reg);
    wire        b_err      = b_mismatch || b_delim || a_align_err_reg;
    wire [11:0] sum_base   = a_first_reg ? 12'h000 : pkt_sum_reg;
    wire [11:0] sum_next   = sum_base + {1'b0, a_size_reg}; // [RULE13]

    // ****************************************************************
    // Byte position inside the buffer
    // ****************************************************************
    wire [11:0] byte_pos  = {word_idx_reg[9:0], lane_reg};
    wire [11:0] start_pos = {7'b000_0000, a_off_reg};
    // Bytes ahead of the offset and past the size are dropped
    wire        in_range  = (byte_pos >= start_pos)
                            && (byte_pos < a_end_reg); // [RULE11]
    wire [11:0] idx_inc   = word_idx_reg + 12'h001;
    wire        word_end  = hold_reg && (lane_reg == 2'b11);

    // Buffer ends after its last word, filler or not [RULE10]
    wire buf_done = (take_b && (words_total_reg == 12'h000))
                    || (word_end && (idx_inc == words_total_reg));

    // Length check closes each packet on its last segment
    wire len_bad  = (pkt_sum_reg[10:0] !=
                     pkt_b_reg[`TBD_B_LEN_HI:`TBD_B_LEN_LO])
                    || pkt_sum_reg[11]; // [RULE13] [RULE14]
    wire pkt_end  = buf_done && a_last_reg;

    // Checks on B must finish before the end test sees the sum
    wire b_now    = take_b && (words_total_reg == 12'h000);
    wire len_bad_now = (sum_next[10:0] !=
                        fifo_word_in[`TBD_B_LEN_HI:`TBD_B_LEN_LO])
                       || sum_next[11];
    wire end_bad  = b_now ? len_bad_now : len_bad;

    wire done_evt = buf_done && a_irq_reg; // [RULE5]
    wire err_evt  = (take_b && b_err) || (pkt_end && end_bad);

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    // Word A, then word B, then data unless the buffer has no words, for every buffer [RULE1] [RULE2]
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg       <= ST_CMD_A;
            a_irq_reg       <= 1'b0;
            a_first_reg     <= 1'b0;
            a_last_reg      <= 1'b0;
            a_align_err_reg <= 1'b0;
            a_off_reg       <= 5'h00;
            a_size_reg      <= 11'h000;
            a_end_reg       <= 12'h000;
            words_total_reg <= 12'h000;
            word_idx_reg    <= 12'h000;
            hold_reg        <= 1'b0;
            lane_reg        <= 2'b00;
            data_reg        <= `TBD_RST_WORD;
        end else begin
            if (take_a) begin
                state_reg       <= ST_CMD_B;
                a_irq_reg       <= fifo_word_in[`TBD_A_IRQ_BIT];
                a_first_reg     <= fifo_word_in[`TBD_A_FIRST_BIT];
                a_last_reg      <= fifo_word_in[`TBD_A_LAST_BIT];
                a_align_err_reg <= (in_align == `TBD_ALIGN_RSVD);
                a_off_reg       <= in_off;
                a_size_reg      <= in_size;
                a_end_reg       <= in_end;
                words_total_reg <= in_total;
            end

            if (take_b) begin
                word_idx_reg <= 12'h000;
                state_reg    <= (words_total_reg == 12'h000) ?
                                ST_CMD_A : ST_DATA;
            end

            if (take_data) begin
                data_reg <= fifo_word_in;
                hold_reg <= 1'b1;
                lane_reg <= 2'b00;
            end else if (hold_reg) begin
                lane_reg <= lane_reg + 2'b01;
                if (lane_reg == 2'b11) begin
                    hold_reg     <= 1'b0;
                    word_idx_reg <= idx_inc;
                end
            end

            if (word_end && (idx_inc == words_total_reg)) begin
                state_reg <= ST_CMD_A;
            end
        end
    end

    // ****************************************************************
    // Packet tracking
    // ****************************************************************
    // Word B of the first segment is the reference for the packet
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pkt_b_reg      <= `TBD_RST_WORD;
            pkt_open_reg   <= 1'b0;
            pkt_sum_reg    <= 12'h000;
            pkt_err_reg    <= 1'b0;
            tx_crc_add_out <= 1'b1;
            tx_pad_en_out  <= 1'b1;
        end else begin
            if (take_b) begin
                pkt_sum_reg  <= sum_next;
                pkt_open_reg <= 1'b1;
                if (a_first_reg) begin
                    pkt_b_reg   <= fifo_word_in;
                    pkt_err_reg <= b_err;
                    // Padding off still forces the CRC [RULE15]
                    tx_crc_add_out <= !fifo_word_in[`TBD_B_CRC_DIS_BIT]
                                      || fifo_word_in[`TBD_B_PAD_DIS_BIT];
                    tx_pad_en_out  <= !fifo_word_in[`TBD_B_PAD_DIS_BIT];
                end else begin
                    pkt_err_reg <= pkt_err_reg || b_err;
                end
            end

            if (pkt_end) begin
                pkt_open_reg <= 1'b0; // [RULE12]
            end
        end
    end

    // ****************************************************************
    // Byte output and packet status
    // ****************************************************************
    // Lane 0 carries the lowest byte of each word
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_byte_out       <= 8'h00;
            tx_byte_valid_out <= 1'b0;
            tx_byte_last_out  <= 1'b0;
            status_valid_out  <= 1'b0;
            status_tag_out    <= 16'h0000;
            status_error_out  <= 1'b0;
        end else begin
            tx_byte_valid_out <= hold_reg && in_range; // [RULE10] [RULE11]
            tx_byte_last_out  <= hold_reg && in_range && a_last_reg
                                 && (byte_pos == a_end_reg - 12'h001);

            case (lane_reg)
                2'b00:   tx_byte_out <= data_reg[7:0];
                2'b01:   tx_byte_out <= data_reg[15:8];
                2'b10:   tx_byte_out <= data_reg[23:16];
                default: tx_byte_out <= data_reg[31:24];
            endcase

            status_valid_out <= pkt_end;
            if (pkt_end) begin
                // Tag of a zero-word last buffer comes straight from B
                status_tag_out   <= b_now ?
                    fifo_word_in[`TBD_B_TAG_HI:`TBD_B_TAG_LO] :
                    pkt_b_reg[`TBD_B_TAG_HI:`TBD_B_TAG_LO]; // [RULE4]
                status_error_out <= end_bad || pkt_err_reg
                                    || (take_b && b_err);
            end
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    wire wr_status = reg_write_in && (reg_addr_in == `TBD_ADDR_STATUS);
    wire wr_mask   = reg_write_in && (reg_addr_in == `TBD_ADDR_MASK);
    wire [`TBD_STS_W-1:0] sts_set;
    wire [`TBD_STS_W-1:0] sts_clr;
    wire [`TBD_STS_W-1:0] sts_next;

    assign sts_set[`TBD_STS_DONE_BIT] = done_evt;
    assign sts_set[`TBD_STS_ERR_BIT]  = err_evt; // [RULE3] [RULE14]
    assign sts_clr  = wr_status ? reg_wdata_in[`TBD_STS_W-1:0] :
                      {`TBD_STS_W{1'b0}};
    // An event in the clearing cycle survives the write of one
    assign sts_next = (sts_reg & ~sts_clr) | sts_set;

    // Sticky flags, mask and read data one cycle after the strobe
    always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sts_reg       <= {`TBD_STS_W{1'b0}};
            mask_reg      <= `TBD_RST_MASK;
            reg_rdata_out <= `TBD_RST_WORD;
        end else begin
            sts_reg <= sts_next;

            if (wr_mask) begin
                mask_reg <= reg_wdata_in[`TBD_STS_W-1:0];
            end

            if (reg_read_in) begin
                case (reg_addr_in)
                    `TBD_ADDR_STATUS:
                        reg_rdata_out <= {30'h0000_0000, sts_reg};
                    `TBD_ADDR_MASK:
                        reg_rdata_out <= {30'h0000_0000, mask_reg};
                    `TBD_ADDR_PKT_CMD_B:
                        reg_rdata_out <= pkt_b_reg;
                    `TBD_ADDR_PKT_SUM:
                        reg_rdata_out <= {state_reg, pkt_open_reg,
                                          17'h0_0000, pkt_sum_reg};
                    default:
                        reg_rdata_out <= `TBD_RST_WORD;
                endcase
            end else begin
                reg_rdata_out <= `TBD_RST_WORD;
            end
        end
    end

    // Level interrupt from unmasked sticky flags [RULE6]
    assign irq_out = |(sts_reg & mask_reg);

endmodule // tbd_tx_cmd_decoder
`default_nettype wire

/* hw/tbd_tx_cmd_defs.vh */
// Constants for the transmit buffer command decoder.
`ifndef TBD_TX_CMD_DEFS_VH
`define TBD_TX_CMD_DEFS_VH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define TBD_ADDR_STATUS      8'h00
`define TBD_ADDR_MASK        8'h04
`define TBD_ADDR_PKT_CMD_B   8'h08
`define TBD_ADDR_PKT_SUM     8'h0C

// ********************************************************************
// Status and mask bit positions
// ********************************************************************
`define TBD_STS_DONE_BIT     0
`define TBD_STS_ERR_BIT      1
`define TBD_STS_W            2

// ********************************************************************
// Command word A fields
// ********************************************************************
`define TBD_A_IRQ_BIT        31
`define TBD_A_ALIGN_HI       25
`define TBD_A_ALIGN_LO       24
`define TBD_A_OFF_HI         20
`define TBD_A_OFF_LO         16
`define TBD_A_FIRST_BIT      13
`define TBD_A_LAST_BIT       12
`define TBD_A_SIZE_HI        10
`define TBD_A_SIZE_LO        0

// ********************************************************************
// Command word B fields
// ********************************************************************
`define TBD_B_TAG_HI         31
`define TBD_B_TAG_LO         16
`define TBD_B_CRC_DIS_BIT    13
`define TBD_B_PAD_DIS_BIT    12
`define TBD_B_LEN_HI         10
`define TBD_B_LEN_LO         0

// ********************************************************************
// End alignment encodings and rounding masks in words
// ********************************************************************
`define TBD_ALIGN_4          2'b00
`define TBD_ALIGN_16         2'b01
`define TBD_ALIGN_32         2'b10
`define TBD_ALIGN_RSVD       2'b11
`define TBD_AMASK_4          12'h000
`define TBD_AMASK_16         12'h003
`define TBD_AMASK_32         12'h007

// ********************************************************************
// Reset values
// ********************************************************************
`define TBD_RST_WORD         32'h0000_0000
`define TBD_RST_MASK         2'b00

`endif

/* sim/tb_top.sv */
// Self-checking testbench for the transmit command decoder.
`timescale 1ns/1ps
`default_nettype none
`include "tbd_tx_cmd_defs.vh"
module tb_top;
    logic        core_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic        reg_write_in = 1'b0;
    logic        reg_read_in = 1'b0;
    logic [31:0] fifo_word_in, reg_rdata_out;
    logic        fifo_valid_in, fifo_ready_out, irq_out;
    logic [7:0]  tx_byte_out;
    logic        tx_byte_valid_out, tx_byte_last_out;
    logic        tx_crc_add_out, tx_pad_en_out, status_valid_out;
    logic [15:0] status_tag_out;
    logic        status_error_out;
    logic [7:0]  got_q[$];
    int          err_count = 0, total_checks = 0, cyc = 0;
    int          st_cnt = 0, last_cnt = 0;

    always #5 core_clk_in = ~core_clk_in;
    tbd_host_model host (.core_clk_in(core_clk_in),
        .fifo_ready_out(fifo_ready_out), .fifo_word_in(fifo_word_in),
        .fifo_valid_in(fifo_valid_in));
    tbd_tx_cmd_decoder uut (.core_clk_in(core_clk_in),
        .resetn_in(resetn_in), .fifo_word_in(fifo_word_in),
        .fifo_valid_in(fifo_valid_in), .fifo_ready_out(fifo_ready_out),
        .tx_byte_out(tx_byte_out), .tx_byte_valid_out(tx_byte_valid_out),
        .tx_byte_last_out(tx_byte_last_out),
        .tx_crc_add_out(tx_crc_add_out), .tx_pad_en_out(tx_pad_en_out),
        .status_valid_out(status_valid_out),
        .status_tag_out(status_tag_out),
        .status_error_out(status_error_out), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .irq_out(irq_out));

    // ****************************************************************
    // Monitors, timeout and shared tasks
    // ****************************************************************
    always @(posedge core_clk_in) begin
        if (tx_byte_valid_out === 1'b1) got_q.push_back(tx_byte_out);
        if (tx_byte_last_out === 1'b1) last_cnt++;
        if (status_valid_out === 1'b1) st_cnt++;
        cyc++;
        if (cyc == 20000) begin // Far beyond the few hundred needed
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
        #1; // Let the write land before callers look at irq
    endtask
    task automatic reg_rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge core_clk_in);
        reg_read_in <= 1'b1;
        reg_addr_in <= ad;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out; // Data stands only in this cycle
    endtask
    // Send one buffer and compare every payload byte that comes out
    task automatic run_buf(input logic [31:0] a, input logic [31:0] b,
                           input logic [7:0] base);
        int off, n;
        got_q.delete();
        host.send_buffer(a, b, base);
        repeat (8) @(posedge core_clk_in);
        off = a[20:16];
        n = a[10:0];
        chk("byte count", got_q.size(), n);
        for (int i = 0; i < n && i < got_q.size(); i++)
            chk("byte", got_q[i], 8'(base + off + i));
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        logic [31:0] d;
        chk("crc reset", tx_crc_add_out, 1);
        chk("pad reset", tx_pad_en_out, 1);
        reg_rd(`TBD_ADDR_STATUS, d);
        chk("status reset", d, 0);
        reg_wr(`TBD_ADDR_MASK, 32'hFFFF_FFFF);
        reg_rd(`TBD_ADDR_MASK, d);
        chk("mask rw", d, 3);
        reg_wr(8'h10, 32'h1234_5678); // Unmapped place
        reg_rd(8'h10, d);
        chk("unmapped", d, 0);
        reg_wr(`TBD_ADDR_MASK, 32'h0000_0000);
        $display("t_regs done");
    endtask
    task automatic t_done_irq();
        logic [31:0] d;
        int c0;
        c0 = st_cnt;
        run_buf(32'h8001_3002, 32'hA5C3_0002, 8'h40);
        chk("status count", st_cnt - c0, 1);
        chk("tag", status_tag_out, 16'hA5C3);
        chk("error", status_error_out, 0);
        reg_rd(`TBD_ADDR_STATUS, d);
        chk("done bit", d, 1);
        chk("irq masked", irq_out, 0);
        reg_wr(`TBD_ADDR_MASK, 32'h0000_0001);
        chk("irq on", irq_out, 1);
        reg_wr(`TBD_ADDR_STATUS, 32'h0000_0001);
        chk("irq cleared", irq_out, 0);
        $display("t_done_irq done");
    endtask
    task automatic t_align();
        logic [31:0] d;
        logic [1:0] i2;
        for (int i = 0; i < 4; i++) begin
            i2 = 2'(i);
            run_buf({6'h00, (i == 3) ? 2'h0 : i2, 3'h0, 5'(31 - 8 * i),
                     2'h0, 2'h3, 1'b0, 11'(7 + i)},
                    {16'(i), 2'h0, i2, 1'b0, 11'(7 + i)}, 8'(16 * i));
            chk("crc add", tx_crc_add_out, !i2[1] | i2[0]);
            chk("pad en", tx_pad_en_out, !i2[0]);
            chk("error", status_error_out, 0);
        end
        reg_rd(`TBD_ADDR_STATUS, d);
        chk("no done", d, 0);
        $display("t_align done");
    endtask
    // Two-segment packets, good and bad, then single-segment faults
    task automatic t_multi();
        logic [31:0] d;
        int c0;
        c0 = st_cnt;
        run_buf(32'h0002_2003, 32'h0101_0007, 8'h10);
        chk("no status yet", st_cnt - c0, 0);
        run_buf(32'h0000_1004, 32'h0101_0007, 8'h20);
        chk("status count", st_cnt - c0, 1);
        chk("good error", status_error_out, 0);
        chk("one last", last_cnt, 6);
        run_buf(32'h0000_2003, 32'h0101_0007, 8'h30);
        run_buf(32'h0000_1004, 32'h0102_0007, 8'h40);
        chk("b differs", status_error_out, 1);
        run_buf(32'h0000_3003, 32'h0103_0004, 8'h50);
        chk("length off", status_error_out, 1);
        run_buf(32'h0300_3003, 32'h0104_0003, 8'h60);
        chk("align rsvd", status_error_out, 1);
        chk("status total", st_cnt - c0, 4);
        reg_rd(`TBD_ADDR_STATUS, d);
        chk("error bit", d[1], 1);
        reg_rd(`TBD_ADDR_PKT_CMD_B, d);
        chk("cmd b", d, 32'h0104_0003);
        $display("t_multi done");
    endtask

    initial begin
        repeat (16) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        t_regs();
        t_done_irq();
        t_align();
        t_multi();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire

/* sim/tbd_host_model.sv */
// Host model that writes command words and payload into the FIFO port.
`timescale 1ns/1ps
`default_nettype none
module tbd_host_model (
    input  wire logic        core_clk_in,
    input  wire logic        fifo_ready_out,
    output var  logic [31:0] fifo_word_in,
    output var  logic        fifo_valid_in
);
    initial begin
        fifo_word_in = 32'h0000_0000;
        fifo_valid_in = 1'b0;
    end
    // Hold the word until an edge sees ready high
    task automatic put_word(input logic [31:0] w);
        fifo_word_in <= w;
        fifo_valid_in <= 1'b1;
        @(posedge core_clk_in);
        while (fifo_ready_out !== 1'b1) @(posedge core_clk_in);
    endtask
    // One buffer: A, B, then payload padded to the end alignment
    task automatic send_buffer(input logic [31:0] a, input logic [31:0] b,
                               input logic [7:0] base);
        int nw;
        int am;
        logic [7:0] p;
        nw = (a[20:16] + a[10:0] + 3) / 4;
        am = (a[25:24] == 2'h1) ? 3 : (a[25:24] == 2'h2) ? 7 : 0;
        nw = (nw + am) & ~am; // Filler words up to alignment
        @(posedge core_clk_in);
        // Reserved A bits always written as zero
        put_word({a[31], 5'h00, a[25:24], 3'h0, a[20:0]});
        put_word(b); // Word B in front of every buffer
        for (int k = 0; k < nw; k++) begin
            p = 8'(base + 4 * k);
            put_word({p + 8'h03, p + 8'h02, p + 8'h01, p});
        end
        // No pull on the port: show a changed word once released
        fifo_valid_in <= 1'b0;
        fifo_word_in <= ~fifo_word_in;
    endtask
endmodule // tbd_host_model
`default_nettype wire

/* sim/tbd_tx_cmd_properties.sv */
// Concurrent checks on the ports of the transmit command decoder.
`timescale 1ns/1ps
`default_nettype none
`include "tbd_tx_cmd_defs.vh"
module tbd_tx_cmd_properties (
    input wire logic        core_clk_in,
    input wire logic        resetn_in,
    input wire logic        fifo_valid_in,
    input wire logic        fifo_ready_out,
    input wire logic        tx_byte_valid_out,
    input wire logic        tx_byte_last_out,
    input wire logic        tx_crc_add_out,
    input wire logic        tx_pad_en_out,
    input wire logic        status_valid_out,
    input wire logic [15:0] status_tag_out,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_write_in,
    input wire logic        reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        irq_out
);
    // ****************************************************************
    // Properties, all in the core clock domain
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    // A data word blocks the stream for exactly its four byte lanes
    word_split_a: assert property ($fell(fifo_ready_out) |->
        (!fifo_ready_out)[*4] ##1 fifo_ready_out)
        else $error("ready low count wrong after data word");
    byte_lane_a: assert property (tx_byte_valid_out |->
        !$past(fifo_ready_out)) else $error("byte outside a lane");
    last_byte_a: assert property (tx_byte_last_out |->
        tx_byte_valid_out) else $error("last flag without byte");
    crc_forced_a: assert property (!tx_pad_en_out |->
        tx_crc_add_out) else $error("padding off but crc dropped");
    // Frame controls may only move when a word is taken
    ctrl_latch_a: assert property ($changed({tx_crc_add_out,
        tx_pad_en_out}) |-> $past(fifo_valid_in && fifo_ready_out))
        else $error("frame controls moved without a word");
    status_pulse_a: assert property (status_valid_out |=>
        !status_valid_out) else $error("status longer than a pulse");
    tag_hold_a: assert property (!status_valid_out |->
        $stable(status_tag_out)) else $error("tag moved without status");
    mask_off_a: assert property (reg_write_in &&
        reg_addr_in == `TBD_ADDR_MASK && reg_wdata_in[1:0] == 2'h0
        |=> !irq_out) else $error("irq with all sources masked");
    sts_rsvd_a: assert property (reg_read_in &&
        reg_addr_in == `TBD_ADDR_STATUS |=> reg_rdata_out[31:2] == 30'h0)
        else $error("status reserved bits set");
    rdata_idle_a: assert property (!reg_read_in |=>
        reg_rdata_out == 32'h0000_0000) else $error("read data not idle");
endmodule // tbd_tx_cmd_properties
bind tbd_tx_cmd_decoder tbd_tx_cmd_properties u_props (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .fifo_valid_in(fifo_valid_in), .fifo_ready_out(fifo_ready_out),
    .tx_byte_valid_out(tx_byte_valid_out),
    .tx_byte_last_out(tx_byte_last_out), .tx_crc_add_out(tx_crc_add_out),
    .tx_pad_en_out(tx_pad_en_out), .status_valid_out(status_valid_out),
    .status_tag_out(status_tag_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out));
`default_nettype wire
